// ===== partial_numerator_n_synth_pkg.sv
/*
 * constants, field layouts and enumerations shared by the synthesizer ends.
 * assumes one 40 mhz clock and a word link carrying whole 24-bit words.
 */
// ====================================================================
package partial_numerator_n_synth_pkg;
    localparam int WORD_W = 24;
    // ================================================================
    // register selection
    typedef enum logic [1:0] {
        SEL_FEEDBACK  = 2'b00,
        SEL_REFERENCE = 2'b01,
        SEL_CONTROL   = 2'b10,
        SEL_NOISE     = 2'b11
    } reg_select_e;
    localparam int SEL_LSB = 0;
    // ================================================================
    // feedback divide word fields
    localparam int FB_NUM_LSB  = 2;
    localparam int FB_WHOLE_LSB = 14;
    localparam int FB_FAST_BIT = 23;
    // ================================================================
    // reference divide word fields
    localparam int RF_DEN_LSB   = 2;
    localparam int RF_RATIO_LSB = 14;
    localparam int RF_PRESC_BIT = 18;
    localparam int RF_DIAG_LSB  = 20;
    localparam int RF_LOAD_BIT  = 23;
    // ================================================================
    // control word fields
    localparam int CT_HOLD_BIT = 2;
    localparam int CT_TRI_BIT  = 3;
    localparam int CT_PREC_BIT = 5;
    localparam int CT_CP_LSB   = 7;
    // ================================================================
    // diagnostic pin sources
    typedef enum logic [2:0] {
        DIAG_TRISTATE = 3'b000,
        DIAG_DIG_LOCK = 3'b001,
        DIAG_FB_DIV   = 3'b010,
        DIAG_HIGH     = 3'b011,
        DIAG_REF_DIV  = 3'b100,
        DIAG_ANA_LOCK = 3'b101,
        DIAG_FAST_SW  = 3'b110,
        DIAG_LOW      = 3'b111
    } diag_sel_e;
    // ================================================================
    // reset values and limits
    localparam logic [11:0] DEN_RESET    = 12'h000;
    localparam logic [11:0] DEN_HOST_MAX = 12'hfff;
    localparam logic [3:0]  CP_MAX       = 4'hf;
    localparam logic [5:0]  LOCK_CYC_LOW  = 6'd24;
    localparam logic [5:0]  LOCK_CYC_HIGH = 6'd40;
    localparam logic [8:0]  WHOLE_MIN_45 = 9'd31;
    localparam logic [8:0]  WHOLE_MIN_89 = 9'd91;
    localparam logic [3:0]  RATIO_MIN    = 4'd1;
endpackage : partial_numerator_n_synth_pkg

// ===== synth_link_if.sv
/*
 * word link between host controller and synthesizer.
 * assumes the serial shifting is done outside; load marks a complete word.
 */
interface synth_link_if;
    logic [23:0] word;
    logic        load;
    modport host   (output word, output load);
    modport device (input word, input load);
endinterface : synth_link_if

// ===== lock_detect.sv
/*
 * digital lock detect counter.
 * assumes error comparisons arrive as flags valid on each pfd cycle pulse.
 */
module lock_detect (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pfd_cycle,
    input  wire logic err_below_15ns,
    input  wire logic err_above_30ns,
    input  wire logic new_channel,
    input  wire logic clear,
    input  wire logic precision,
    output logic      lock
);
    import partial_numerator_n_synth_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic       lock;
    } ld_s;

    ld_s st;
    ld_s next_st;
    logic [5:0] target;

    // good-cycle target from precision
    assign target = precision ? LOCK_CYC_HIGH : LOCK_CYC_LOW;

    // counting of successive good cycles
    always_comb begin
        next_st = st;
        if (new_channel || clear) begin
            next_st = '0;
        end else if (pfd_cycle) begin
            if (err_above_30ns) begin
                next_st = '0;
            end else if (err_below_15ns) begin
                if (!st.lock) begin
                    if (st.cnt + 6'd1 >= target) begin
                        next_st.lock = 1'b1;
                    end else begin
                        next_st.cnt = st.cnt + 6'd1;
                    end
                end
            end else begin
                next_st.cnt = 6'd0; // middle band breaks the run, lock kept
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lock = st.lock;
endmodule : lock_detect

// ===== synth_device.sv
/*
 * synthesizer digital end: word decode, double-buffered denominator,
 * reference counter, pump control, diagnostic pin, lock detect.
 * assumes rf-side dividers and error comparators are outside, seen as pulses.
 * assumes the link delivers a whole word with a one-cycle load strobe and
 * that the select field sits in the two lowest bits of that word.
 */
module synth_device (
    input  wire logic        clk,
    input  wire logic        rst_n,
    synth_link_if.device     link,
    input  wire logic        ref_in_tick,
    input  wire logic        fb_div_pulse,
    input  wire logic        analog_lock,
    input  wire logic        err_below_15ns,
    input  wire logic        err_above_30ns,
    output logic [8:0]       whole_divide_value,
    output logic [11:0]      partial_numerator,
    output logic [11:0]      fraction_denominator,
    output logic [11:0]      resync_delay,
    output logic             prescaler_select_bit,
    output logic [3:0]       ref_ratio,
    output logic             ref_div_pulse,
    output logic [3:0]       pump_current,
    output logic             pump_three_state,
    output logic             counters_held,
    output logic             digital_lock,
    output logic             diag_pin_o,
    output logic             diag_pin_oe
);
    import partial_numerator_n_synth_pkg::*;

    typedef struct packed {
        logic [8:0]  whole;
        logic [11:0] numer;
        logic        fast;
        logic [11:0] pend_den;
        logic [11:0] act_den;
        logic [11:0] resync;
        logic [2:0]  diag;
        logic        presc;
        logic [3:0]  ratio;
        logic [3:0]  ref_cnt;
        logic        ref_out;
        logic        hold;
        logic        tri_st;
        logic        precision;
        logic [3:0]  cp_cur;
        logic [3:0]  pump;
        logic        pin_o;
        logic        pin_oe;
        logic        new_chan;
    } dev_s;

    dev_s        st;
    dev_s        next_st;
    logic [1:0]  sel;
    logic [23:0] w;
    logic        lock;

    // fields of the word on the link, named once for the decoder
    logic [8:0]  fb_whole;
    logic [11:0] fb_numer;
    logic        fb_fast;
    logic [11:0] rf_den;
    logic        rf_load;
    logic [2:0]  rf_diag;
    logic        rf_presc;
    logic [3:0]  rf_ratio;
    logic        ct_hold;
    logic        ct_tri;
    logic        ct_prec;
    logic [3:0]  ct_cp;

    assign w   = link.word;
    assign sel = w[SEL_LSB +: 2];

    // field extraction, positions shared with the host end
    assign fb_whole = w[FB_WHOLE_LSB +: 9];
    assign fb_numer = w[FB_NUM_LSB +: 12];
    assign fb_fast  = w[FB_FAST_BIT];
    assign rf_den   = w[RF_DEN_LSB +: 12];
    assign rf_load  = w[RF_LOAD_BIT];
    assign rf_diag  = w[RF_DIAG_LSB +: 3];
    assign rf_presc = w[RF_PRESC_BIT];
    assign rf_ratio = w[RF_RATIO_LSB +: 4];
    assign ct_hold  = w[CT_HOLD_BIT];
    assign ct_tri   = w[CT_TRI_BIT];
    assign ct_prec  = w[CT_PREC_BIT];
    assign ct_cp    = w[CT_CP_LSB +: 4];

    // ================================================================
    // lock detection
    lock_detect u_lock (
        .clk            (clk),
        .rst_n          (rst_n),
        .pfd_cycle      (st.ref_out),
        .err_below_15ns (err_below_15ns),
        .err_above_30ns (err_above_30ns),
        .new_channel    (st.new_chan),
        .clear          (st.hold),
        .precision      (st.precision),
        .lock           (lock)
    );

    // ================================================================
    // next state
    always_comb begin
        next_st          = st;
        next_st.new_chan = 1'b0;
        next_st.ref_out  = 1'b0;
        // word decode, fields move only on a complete word
        if (link.load) begin
            case (sel)
                SEL_FEEDBACK: begin
                    next_st.whole    = fb_whole;
                    next_st.numer    = fb_numer;
                    next_st.fast     = fb_fast;
                    // the pending denominator becomes active only here
                    next_st.act_den  = st.pend_den;
                    next_st.new_chan = 1'b1;
                end
                SEL_REFERENCE: begin
                    // a resync word leaves the pending denominator alone
                    if (rf_load) begin
                        next_st.resync = rf_den;
                    end else begin
                        next_st.pend_den = rf_den;
                    end
                    next_st.diag  = rf_diag;
                    next_st.presc = rf_presc;
                    next_st.ratio = rf_ratio;
                end
                SEL_CONTROL: begin
                    next_st.hold      = ct_hold;
                    next_st.tri_st    = ct_tri;
                    next_st.precision = ct_prec;
                    next_st.cp_cur    = ct_cp;
                end
                default: begin
                    next_st.new_chan = 1'b0; // noise register not kept here
                end
            endcase
        end
        // pump current registered together with the fields it follows
        next_st.pump = next_st.fast ? CP_MAX : next_st.cp_cur;
        // reference counter, held cleared by the hold bit
        if (st.hold) begin
            next_st.ref_cnt = 4'd0;
        end else if (ref_in_tick) begin
            if (st.ref_cnt + 4'd1 >= st.ratio) begin
                next_st.ref_cnt = 4'd0;
                next_st.ref_out = 1'b1;
            end else begin
                next_st.ref_cnt = st.ref_cnt + 4'd1;
            end
        end
        // diagnostic pin source
        next_st.pin_oe = 1'b1;
        case (diag_sel_e'(st.diag))
            DIAG_TRISTATE: begin
                next_st.pin_o  = 1'b0;
                next_st.pin_oe = 1'b0;
            end
            DIAG_DIG_LOCK: next_st.pin_o = lock;
            DIAG_FB_DIV:   next_st.pin_o = fb_div_pulse & ~st.hold;
            DIAG_HIGH:     next_st.pin_o = 1'b1;
            DIAG_REF_DIV:  next_st.pin_o = st.ref_out;
            DIAG_ANA_LOCK: next_st.pin_o = analog_lock;
            DIAG_FAST_SW: begin
                next_st.pin_o  = 1'b0;
                next_st.pin_oe = st.fast;
            end
            DIAG_LOW:      next_st.pin_o = 1'b0;
            default: begin
                next_st.pin_o  = 1'b0;
                next_st.pin_oe = 1'b0;
            end
        endcase
    end

    // ================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.pend_den <= DEN_RESET;
            st.act_den  <= DEN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ================================================================
    // outputs
    assign whole_divide_value   = st.whole;
    assign partial_numerator    = st.numer;
    assign fraction_denominator = st.act_den;
    assign resync_delay         = st.resync;
    assign prescaler_select_bit = st.presc;
    assign ref_ratio            = st.ratio;
    assign ref_div_pulse        = st.ref_out;
    assign pump_current         = st.pump;
    assign pump_three_state     = st.tri_st;
    assign counters_held        = st.hold;
    assign digital_lock         = lock;
    assign diag_pin_o           = st.pin_o;
    assign diag_pin_oe          = st.pin_oe;
endmodule : synth_device

// ===== synth_host.sv
/*
 * host controller end: checks words, forces prescaler above 2 ghz,
 * follows every denominator change made after a first feedback word with a resend of the last feedback word.
 * assumes the user offers whole 24-bit words with select bits in place.
 */
module synth_host (
    input  wire logic        clk,
    input  wire logic        rst_n,
    synth_link_if.host       link,
    input  wire logic        req_valid,
    input  wire logic [23:0] req_word,
    input  wire logic        rf_above_2ghz,
    output logic             req_ready,
    output logic             req_rejected
);
    import partial_numerator_n_synth_pkg::*;

    typedef enum logic [0:0] {
        S_IDLE   = 1'b0,
        S_FOLLOW = 1'b1
    } host_state_e;

    typedef struct packed {
        host_state_e state;
        logic [23:0] word;
        logic        load;
        logic        rejected;
        logic [11:0] den;
        logic        presc;
        logic [23:0] last_fb;
        logic        fb_valid;
    } host_s;

    host_s       st;
    host_s       next_st;
    logic [23:0] w;
    logic [1:0]  sel;
    logic        bad;

    assign sel       = req_word[SEL_LSB +: 2];
    assign req_ready = (st.state == S_IDLE);

    // word screening and prescaler forcing
    always_comb begin
        w   = req_word;
        bad = 1'b0;
        if (sel == SEL_REFERENCE) begin
            if (rf_above_2ghz) begin
                w[RF_PRESC_BIT] = 1'b1;
            end
            if (req_word[RF_RATIO_LSB +: 4] < RATIO_MIN) begin
                bad = 1'b1;
            end
        end else if (sel == SEL_FEEDBACK) begin
            if (req_word[FB_WHOLE_LSB +: 9] < (st.presc ? WHOLE_MIN_89 : WHOLE_MIN_45)) begin
                bad = 1'b1;
            end
            if (req_word[FB_NUM_LSB +: 12] > st.den) begin
                bad = 1'b1;
            end
        end
    end

    // sequencing of words onto the link
    always_comb begin
        next_st          = st;
        next_st.load     = 1'b0;
        next_st.rejected = 1'b0;
        case (st.state)
            S_IDLE: begin
                if (req_valid) begin
                    if (bad) begin
                        next_st.rejected = 1'b1;
                    end else begin
                        next_st.word = w;
                        next_st.load = 1'b1;
                        if (sel == SEL_FEEDBACK) begin
                            next_st.last_fb  = w;
                            next_st.fb_valid = 1'b1;
                        end
                        if (sel == SEL_REFERENCE) begin
                            next_st.presc = w[RF_PRESC_BIT];
                            if (!w[RF_LOAD_BIT]) begin
                                next_st.den = w[RF_DEN_LSB +: 12];
                                if (st.fb_valid) begin
                                    next_st.state = S_FOLLOW;
                                end
                            end
                        end
                    end
                end
            end
            S_FOLLOW: begin
                next_st.word  = st.last_fb;
                next_st.load  = 1'b1;
                next_st.state = S_IDLE;
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st     <= '0;
            st.den <= DEN_HOST_MAX;
        end else begin
            st <= next_st;
        end
    end

    assign link.word    = st.word;
    assign link.load    = st.load;
    assign req_rejected = st.rejected;
endmodule : synth_host

// ===== synth_link_chk.sv
/*
 * checker of the word link between host end and device end.
 * assumes the link signals and the clock domain are fed in beside the link.
 */
module synth_link_chk (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [23:0] word,
    input  wire logic        load
);
    import partial_numerator_n_synth_pkg::*;
    logic        is_fb;
    logic        is_rf;
    logic        pres_sh;
    logic        fb_seen;
    logic        fu;
    logic [11:0] den_sh;
    logic [23:0] last_fb;
    // ================================================================
    // shadows of what the host end has sent
    assign is_fb = load && word[1:0] == 2'h0;
    assign is_rf = load && word[1:0] == 2'h1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pres_sh <= 1'h0;
            fb_seen <= 1'h0;
            fu      <= 1'h0;
            den_sh  <= DEN_HOST_MAX;
            last_fb <= 24'h0;
        end else begin
            fu <= is_rf && !word[23] && fb_seen;
            if (is_rf) pres_sh <= word[18];
            if (is_rf && !word[23]) den_sh <= word[13:2];
            if (is_fb) fb_seen <= 1'h1;
            if (is_fb) last_fb <= word;
        end
    end
    // ================================================================
    // properties of the link
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_followup;
        is_rf && !word[23] && fb_seen |=> load && word == last_fb;
    endproperty
    a_followup: assert property (p_followup) else $error("no feedback resend");
    property p_resync;
        is_rf && word[23] |=> !is_fb;
    endproperty
    a_resync: assert property (p_resync) else $error("resend after resync word");
    property p_min45;
        is_fb && !fu && !pres_sh |-> word[22:14] >= WHOLE_MIN_45;
    endproperty
    a_min45: assert property (p_min45) else $error("whole value too low");
    property p_min89;
        is_fb && !fu && pres_sh |-> word[22:14] >= WHOLE_MIN_89;
    endproperty
    a_min89: assert property (p_min89) else $error("whole value too low");
    property p_num;
        is_fb && !fu |-> word[13:2] <= den_sh;
    endproperty
    a_num: assert property (p_num) else $error("numerator above denominator");
    property p_ratio;
        is_rf |-> word[17:14] != 4'h0;
    endproperty
    a_ratio: assert property (p_ratio) else $error("zero reference ratio");
    property p_hold;
        !load |-> $stable(word);
    endproperty
    a_hold: assert property (p_hold) else $error("word moved without load");
    property p_quiet;
        !$past(rst_n) |-> !load;
    endproperty
    a_quiet: assert property (p_quiet) else $error("load right after reset");
endmodule : synth_link_chk

// ===== test_partial_numerator_n_synth_program_regs.sv
/*
 * testbench joining host end and device end over the word link.
 * assumes the package, link interface and both ends are compiled first.
 */
module test_partial_numerator_n_synth_program_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import partial_numerator_n_synth_pkg::*;
    logic        clk, rst_n, req_valid, rf_above_2ghz, req_ready, req_rejected;
    logic        ref_in_tick, err_below_15ns, err_above_30ns, ref_div_pulse;
    logic        prescaler_select_bit, pump_three_state, counters_held;
    logic        digital_lock, diag_pin_o, diag_pin_oe;
    logic        fb_div_pulse, analog_lock, fb_sent;
    logic [23:0] req_word;
    logic [8:0]  whole_divide_value;
    logic [11:0] partial_numerator, fraction_denominator, resync_delay;
    logic [3:0]  ref_ratio, pump_current;
    int          n_errors, n_compared, cycles;
    // ================================================================
    // both ends and the checker
    synth_link_if link ();
    synth_host u_synth_host (.clk(clk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
        .req_word(req_word), .rf_above_2ghz(rf_above_2ghz), .req_ready(req_ready),
        .req_rejected(req_rejected));
    synth_device u_synth_device (.clk(clk), .rst_n(rst_n), .link(link),
        .ref_in_tick(ref_in_tick), .fb_div_pulse(fb_div_pulse), .analog_lock(analog_lock),
        .err_below_15ns(err_below_15ns), .err_above_30ns(err_above_30ns),
        .whole_divide_value(whole_divide_value), .partial_numerator(partial_numerator),
        .fraction_denominator(fraction_denominator), .resync_delay(resync_delay),
        .prescaler_select_bit(prescaler_select_bit), .ref_ratio(ref_ratio),
        .ref_div_pulse(ref_div_pulse), .pump_current(pump_current),
        .pump_three_state(pump_three_state), .counters_held(counters_held),
        .digital_lock(digital_lock), .diag_pin_o(diag_pin_o), .diag_pin_oe(diag_pin_oe));
    synth_link_chk u_synth_link_chk (.clk(clk), .rst_n(rst_n), .word(link.word),
        .load(link.load));
    // ================================================================
    // word builders, compare, send
    function automatic logic [23:0] fbw(input logic f, input logic [8:0] n,
                                        input logic [11:0] k);
        return {f, n, k, SEL_FEEDBACK};
    endfunction : fbw
    function automatic logic [23:0] rfw(input logic l, input logic [2:0] d, input logic p,
                                        input logic [3:0] r, input logic [11:0] m);
        return {l, d, 1'b0, p, r, m, SEL_REFERENCE};
    endfunction : rfw
    function automatic logic [23:0] ctw(input logic pr, input logic t, input logic h);
        return {13'h0, 4'h5, 1'b0, pr, 1'b0, t, h, SEL_CONTROL};
    endfunction : ctw
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic send(input logic [23:0] w, input logic rej);
        logic follow;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b1;
        req_word  <= w;
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        chk("rejected", rej, req_rejected);
        follow = !rej && w[1:0] == SEL_REFERENCE && !w[RF_LOAD_BIT] && fb_sent;
        chk("ready", !follow, req_ready);
        if (!rej && w[1:0] == SEL_FEEDBACK) fb_sent = 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : send
    // ================================================================
    // scenarios
    task automatic t_fields;
        int k;
        k = 0;
        send(ctw(1'b0, 1'b1, 1'b1), 1'b0);
        chk("held", 1'b1, counters_held);
        chk("tri", 1'b1, pump_three_state);
        repeat (8) begin
            @(negedge clk);
            if (ref_div_pulse) k++;
        end
        chk("pulses", 0, k);
        send(rfw(1'b0, DIAG_FAST_SW, 1'b0, 4'h2, 12'h064), 1'b0);
        chk("ratio", 4'h2, ref_ratio);
        chk("den", 12'h000, fraction_denominator);
        send(fbw(1'b1, 9'd40, 12'h01e), 1'b0);
        chk("whole", 9'd40, whole_divide_value);
        chk("num", 12'h01e, partial_numerator);
        chk("den", 12'h064, fraction_denominator);
        chk("cp", CP_MAX, pump_current);
        chk("pin", 2'h2, {diag_pin_oe, diag_pin_o});
        send(fbw(1'b0, 9'd40, 12'h01e), 1'b0);
        chk("cp", 4'h5, pump_current);
        chk("oe", 1'b0, diag_pin_oe);
        send(ctw(1'b0, 1'b0, 1'b0), 1'b0);
        chk("held", 1'b0, counters_held);
        chk("tri", 1'b0, pump_three_state);
    endtask : t_fields
    task automatic t_resync;
        send(rfw(1'b1, DIAG_FAST_SW, 1'b0, 4'h2, 12'h007), 1'b0);
        chk("resync", 12'h007, resync_delay);
        chk("den", 12'h064, fraction_denominator);
        send(rfw(1'b0, DIAG_FAST_SW, 1'b0, 4'h2, 12'h0c8), 1'b0);
        chk("den", 12'h0c8, fraction_denominator);
        send(24'hffffff, 1'b0);
        chk("den", 12'h0c8, fraction_denominator);
        chk("held", 1'b0, counters_held);
    endtask : t_resync
    task automatic t_refuse;
        send(fbw(1'b0, 9'd30, 12'h000), 1'b1);
        send(fbw(1'b0, 9'd40, 12'h0c9), 1'b1);
        send(rfw(1'b0, DIAG_FAST_SW, 1'b0, 4'h0, 12'h0c8), 1'b1);
        @(posedge clk);
        rf_above_2ghz <= 1'b1;
        send(rfw(1'b0, DIAG_FAST_SW, 1'b0, 4'hf, 12'h0c8), 1'b0);
        chk("presc", 1'b1, prescaler_select_bit);
        send(fbw(1'b0, 9'd90, 12'h000), 1'b1);
        send(fbw(1'b0, 9'd91, 12'h000), 1'b0);
        chk("whole", 9'd91, whole_divide_value);
    endtask : t_refuse
    task automatic t_diag;
        @(posedge clk);
        fb_div_pulse <= 1'b1;
        analog_lock  <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            send(rfw(1'b1, 3'(i), 1'b1, 4'h1, 12'h000), 1'b0);
            if (i == 3) chk("pin", 2'h3, {diag_pin_oe, diag_pin_o});
            if (i == 1 || i == 2 || i == 4 || i == 5) begin
                chk("pin", {1'b1, i != 1}, {diag_pin_oe, diag_pin_o});
            end
            if (i == 7) chk("pin", 2'h2, {diag_pin_oe, diag_pin_o});
            if (i == 0 || i == 6) chk("oe", 1'b0, diag_pin_oe);
        end
    endtask : t_diag
    task automatic t_lock(input logic prec, input int n);
        int k;
        k = 0;
        send(ctw(prec, 1'b0, 1'b0), 1'b0);
        send(rfw(1'b1, DIAG_DIG_LOCK, 1'b1, 4'h3, 12'h000), 1'b0);
        repeat (9) begin
            @(negedge clk);
            if (ref_div_pulse) k++;
        end
        chk("pulses", 3, k);
        k = 0;
        @(posedge clk);
        err_below_15ns <= 1'b1;
        while (k < n - 1) begin
            @(negedge clk);
            if (ref_div_pulse) k++;
        end
        @(negedge clk);
        chk("early lock", 1'b0, digital_lock);
        repeat (4) @(negedge clk);
        chk("lock", 1'b1, digital_lock);
        chk("pin", 2'h3, {diag_pin_oe, diag_pin_o});
        @(posedge clk);
        err_below_15ns <= 1'b0;
        repeat (4) @(negedge clk);
        chk("kept lock", 1'b1, digital_lock);
        @(posedge clk);
        err_above_30ns <= prec == 1'b0;
        if (prec) send(fbw(1'b0, 9'd91, 12'h000), 1'b0);
        repeat (3) @(posedge clk);
        err_above_30ns <= 1'b0;
        @(negedge clk);
        chk("lost lock", 1'b0, digital_lock);
    endtask : t_lock
    // ================================================================
    // clock, watchdog, main sequence
    task automatic end_of_test;
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_word = 24'h0;
        rf_above_2ghz = 1'b0;
        ref_in_tick = 1'b1;
        err_below_15ns = 1'b0;
        err_above_30ns = 1'b0;
        fb_div_pulse = 1'b0;
        analog_lock = 1'b0;
        fb_sent = 1'b0;
        n_errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_fields();
        t_resync();
        t_refuse();
        t_diag();
        t_lock(1'b0, 24);
        t_lock(1'b1, 40);
        end_of_test();
    end
endmodule : test_partial_numerator_n_synth_program_regs
